//--- rtl/ulpiss_brownout.sv
// power-on reset generator with brownout dip filter
// assumes supply_ok is already synchronised to clk
`timescale 1ns/10ps
`default_nettype none
`include "ulpiss_regs.svh"
module ulpiss_brownout (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // supply level in, reset pulse out
  ulpiss_por_if.filt pif
);
  logic [`ULPISS_CNT_W-1:0] low_cnt_r;
  logic [`ULPISS_CNT_W-1:0] pulse_cnt_r;
  logic armed_r;
  logic trig;

  // fire on the first crossing, then on a dip that outlasts the width
  assign trig = pif.enable && pif.supply_ok &&
                (!armed_r || low_cnt_r >=
                 `ULPISS_CNT_W'(`ULPISS_BROWNOUT_CYC));

  // count cycles spent below the trip level
  always_ff @(posedge clk) begin
    if (reset || !pif.enable || pif.supply_ok) begin
      low_cnt_r <= '0;
    end else if (low_cnt_r != {`ULPISS_CNT_W{1'b1}}) begin
      low_cnt_r <= low_cnt_r + `ULPISS_CNT_W'(1);
    end
  end

  // remember that the supply has crossed once; short dips are ignored
  always_ff @(posedge clk) begin
    if (reset || !pif.enable) begin
      armed_r <= 1'b0;
    end else if (pif.supply_ok) begin
      armed_r <= 1'b1;
    end
  end

  // stretch the trigger into a fixed-length pulse
  always_ff @(posedge clk) begin
    if (reset || !pif.enable) begin
      pulse_cnt_r <= '0;
    end else if (trig) begin
      pulse_cnt_r <= `ULPISS_CNT_W'(`ULPISS_POR_CYC);
    end else if (pulse_cnt_r != '0) begin
      pulse_cnt_r <= pulse_cnt_r - `ULPISS_CNT_W'(1);
    end
  end

  assign pif.por = trig || (pulse_cnt_r != '0);
endmodule
`default_nettype wire

//--- rtl/ulpiss_pkg.sv
// types shared by the ulpi start-up sequencer
// assumes nothing beyond a systemverilog compiler
package ulpiss_pkg;
  typedef enum logic [3:0] {
    ST_OFF,
    ST_POR,
    ST_PLL,
    ST_RXCMD,
    ST_DROP,
    ST_READY,
    ST_RST_TA,
    ST_RST
  } ulpiss_state_e;
  typedef logic [7:0] ulpiss_byte_t;
endpackage

//--- rtl/ulpiss_por_if.sv
// carrier between the sequencer and its brownout filter
// assumes both ends share one clock
`timescale 1ns/10ps
`default_nettype none
interface ulpiss_por_if;
  logic supply_ok;
  logic enable;
  logic por;
  modport filt (input supply_ok, input enable, output por);
  modport seq (output supply_ok, output enable, input por);
endinterface
`default_nettype wire

//--- rtl/ulpiss_regs.svh
// timing counts and reset values for the ulpi start-up sequencer
// assumes the sequencer clock runs at 50 MHz
`ifndef ULPISS_REGS_SVH
`define ULPISS_REGS_SVH

`define ULPISS_CLK_MHZ 50
// least time a core supply dip must last to retrigger power-on reset
`define ULPISS_BROWNOUT_MIN_WIDTH_NS 1000
`define ULPISS_BROWNOUT_CYC ((`ULPISS_BROWNOUT_MIN_WIDTH_NS*`ULPISS_CLK_MHZ+999)/1000)
// length of the internal power-on reset pulse
`define ULPISS_POR_PULSE_NS 200
`define ULPISS_POR_CYC ((`ULPISS_POR_PULSE_NS*`ULPISS_CLK_MHZ+999)/1000)
// length of the internal reset started by the function reset bit
`define ULPISS_FUNC_RST_NS 2000
`define ULPISS_FUNC_RST_CYC ((`ULPISS_FUNC_RST_NS*`ULPISS_CLK_MHZ+999)/1000)
`define ULPISS_CNT_W 16
`define ULPISS_DATA_IDLE 8'h00

`endif

//--- rtl/ulpiss_top.sv
// ulpi transceiver start-up, reset, power-down and bus guard sequencer
// assumes clk is the interface clock source that the pll yields; pins
// and supply detectors are asynchronous and are synchronised here
`timescale 1ns/10ps
`default_nettype none
`include "ulpiss_regs.svh"

// Operation
// - power-on reset runs with direction held high
// - pll settled: release direction, run interface clock
// - direction high until reset ends, self-clear bit
// - one status byte after every completed reset
// - i/o supply absent or deselected: float pins, power down
// - stp pull-up; stray stp enables data pull-downs
// - guard disable bit turns the guard off
// - por on crossing; only long dips retrigger
// - one turnaround cycle on every direction change
// - deselected device ignores stp entirely
module ulpiss_top #(
  parameter bit CHIP_SEL_ACTIVE_HIGH = 1'b1
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // supply detectors and pll, asynchronous
  input wire logic io_supply_ok,
  input wire logic core_supply_ok,
  input wire logic pll_locked,
  // device select pin, asynchronous
  input wire logic chip_sel_pin,
  // control from the register block, same clock
  input wire logic func_reset_set,
  input wire logic bus_guard_disable,
  input wire logic link_xfer_active,
  input wire ulpiss_pkg::ulpiss_byte_t line_status,
  // stp pin
  input wire logic stp_in,
  output logic stp_pullup_en,
  // dir pin
  output logic dir_out,
  output logic dir_oe,
  // nxt pin
  output logic nxt_out,
  output logic nxt_oe,
  // data pins
  output ulpiss_pkg::ulpiss_byte_t data_out,
  output logic data_oe,
  output logic data_pulldown_en,
  // interface clock pin
  output logic clock_run,
  output logic clock_oe,
  // status and power
  output logic func_reset_bit,
  output logic regulator_en,
  output logic rxcmd_sent
);
  ulpiss_pkg::ulpiss_state_e state_r;
  ulpiss_pkg::ulpiss_state_e state_nxt;
  logic [1:0] io_sync_r;
  logic [1:0] core_sync_r;
  logic [1:0] pll_sync_r;
  logic [1:0] cs_sync_r;
  logic [1:0] stp_sync_r;
  logic selected;
  logic stp_seen;
  logic [`ULPISS_CNT_W-1:0] rst_cnt_r;
  logic rst_bit_r;
  logic dir_r;
  logic data_oe_r;
  logic pulldown_r;
  logic rxcmd_sent_r;
  ulpiss_pkg::ulpiss_byte_t data_r;
  ulpiss_por_if por_if ();

  // two-stage synchronisers for every asynchronous input
  always_ff @(posedge clk) begin
    if (reset) begin
      io_sync_r <= 2'h0;
      core_sync_r <= 2'h0;
      pll_sync_r <= 2'h0;
      cs_sync_r <= 2'h0;
      stp_sync_r <= 2'h0;
    end else begin
      io_sync_r <= {io_sync_r[0], io_supply_ok};
      core_sync_r <= {core_sync_r[0], core_supply_ok};
      pll_sync_r <= {pll_sync_r[0], pll_locked};
      cs_sync_r <= {cs_sync_r[0], chip_sel_pin};
      stp_sync_r <= {stp_sync_r[0], stp_in};
    end
  end

  // powered only with i/o supply present and select active
  assign selected = io_sync_r[1] &&
                    (cs_sync_r[1] == CHIP_SEL_ACTIVE_HIGH);
  // stp is ignored while deselected
  assign stp_seen = selected && stp_sync_r[1];

  // brownout filter sees the core supply only while powered
  assign por_if.supply_ok = core_sync_r[1];
  assign por_if.enable = selected;

  ulpiss_brownout u_brownout (
    .clk(clk),
    .reset(reset),
    .pif(por_if.filt)
  );

  // next state of the start-up and reset sequence
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ulpiss_pkg::ST_OFF: begin
        if (selected) begin
          state_nxt = ulpiss_pkg::ST_POR;
        end
      end
      ulpiss_pkg::ST_POR: begin
        if (!por_if.por && core_sync_r[1]) begin
          state_nxt = ulpiss_pkg::ST_PLL;
        end
      end
      ulpiss_pkg::ST_PLL: begin
        if (pll_sync_r[1]) begin
          state_nxt = ulpiss_pkg::ST_RXCMD;
        end
      end
      ulpiss_pkg::ST_RXCMD: begin
        state_nxt = ulpiss_pkg::ST_DROP;
      end
      ulpiss_pkg::ST_DROP: begin
        state_nxt = ulpiss_pkg::ST_READY;
      end
      ulpiss_pkg::ST_READY: begin
        if (func_reset_set) begin
          state_nxt = ulpiss_pkg::ST_RST_TA;
        end
      end
      ulpiss_pkg::ST_RST_TA: begin
        state_nxt = ulpiss_pkg::ST_RST;
      end
      ulpiss_pkg::ST_RST: begin
        if (rst_cnt_r == '0) begin
          state_nxt = ulpiss_pkg::ST_RXCMD;
        end
      end
      default: begin
        state_nxt = ulpiss_pkg::ST_OFF;
      end
    endcase
    if (!selected) begin
      state_nxt = ulpiss_pkg::ST_OFF;
    end else if (por_if.por) begin
      state_nxt = ulpiss_pkg::ST_POR;
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (reset) begin
      state_r <= ulpiss_pkg::ST_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  // internal reset duration counter
  always_ff @(posedge clk) begin
    if (reset || state_r != ulpiss_pkg::ST_RST) begin
      rst_cnt_r <= `ULPISS_CNT_W'(`ULPISS_FUNC_RST_CYC - 1);
    end else if (rst_cnt_r != '0) begin
      rst_cnt_r <= rst_cnt_r - `ULPISS_CNT_W'(1);
    end
  end

  // reset bit: set by the link, cleared once the reset completes
  always_ff @(posedge clk) begin
    if (reset || !selected) begin
      rst_bit_r <= 1'b0;
    end else if (func_reset_set) begin
      rst_bit_r <= 1'b1;
    end else if (state_r == ulpiss_pkg::ST_RST && rst_cnt_r == '0) begin
      rst_bit_r <= 1'b0;
    end
  end

  // direction is high except when off, ready or in the falling turnaround
  always_ff @(posedge clk) begin
    if (reset) begin
      dir_r <= 1'b0;
    end else begin
      dir_r <= !(state_nxt == ulpiss_pkg::ST_OFF ||
                 state_nxt == ulpiss_pkg::ST_DROP ||
                 state_nxt == ulpiss_pkg::ST_READY);
    end
  end

  // device drives data only while direction is high and settled
  always_ff @(posedge clk) begin
    if (reset) begin
      data_oe_r <= 1'b0;
    end else begin
      data_oe_r <= dir_r &&
                   (state_nxt == ulpiss_pkg::ST_POR ||
                    state_nxt == ulpiss_pkg::ST_PLL ||
                    state_nxt == ulpiss_pkg::ST_RST ||
                    state_nxt == ulpiss_pkg::ST_RXCMD);
    end
  end

  // status byte goes out in the cycle before direction falls
  always_ff @(posedge clk) begin
    if (reset) begin
      data_r <= `ULPISS_DATA_IDLE;
      rxcmd_sent_r <= 1'b0;
    end else begin
      rxcmd_sent_r <= (state_nxt == ulpiss_pkg::ST_RXCMD);
      if (state_nxt == ulpiss_pkg::ST_RXCMD) begin
        data_r <= line_status;
      end else begin
        data_r <= `ULPISS_DATA_IDLE;
      end
    end
  end

  // stray stp outside a link transfer turns on the data pull-downs
  always_ff @(posedge clk) begin
    if (reset) begin
      pulldown_r <= 1'b0;
    end else begin
      pulldown_r <= stp_seen && !link_xfer_active && !dir_r &&
                    !bus_guard_disable;
    end
  end

  // pin drive; all pins float while powered down
  assign stp_pullup_en = selected;
  assign dir_out = dir_r;
  assign dir_oe = selected;
  assign nxt_out = 1'b0; // status bytes never raise nxt
  assign nxt_oe = selected;
  assign data_out = data_r;
  assign data_oe = data_oe_r && selected;
  assign data_pulldown_en = pulldown_r && selected;
  // interface clock runs once the pll has settled
  assign clock_run = selected && state_r != ulpiss_pkg::ST_OFF &&
                     state_r != ulpiss_pkg::ST_POR &&
                     state_r != ulpiss_pkg::ST_PLL;
  assign clock_oe = clock_run;
  assign func_reset_bit = rst_bit_r;
  assign regulator_en = selected;
  assign rxcmd_sent = rxcmd_sent_r;
endmodule
`default_nettype wire

//--- testbench/tb_ulpiss_top.sv
// self-checking bench for the ulpi start-up sequencer
// assumes the link model and the bound checker beside it
`timescale 1ns/10ps
`default_nettype none
module tb_ulpiss_top;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic io_ok = 1'b0, core_ok = 1'b0, pll = 1'b0, csel = 1'b0;
  logic go = 1'b0, gdis = 1'b0, xfer = 1'b0, stp = 1'b0;
  logic rst_set, dir, dir_oe, doe, pd, crun, fbit, reg_en, rx;
  logic nxt, nxt_oe;
  ulpiss_pkg::ulpiss_byte_t dout, ldata, rx_byte;
  int error_cnt = 0;
  int n_compared = 0;
  int cyc = 0;
  int rx_n = 0;
  // clock of 20 ns
  always #10 clk = ~clk;
  // status bytes seen on the bus, sampled mid-cycle where they stand
  always @(negedge clk) if (rx === 1'b1) begin
    rx_n++;
    rx_byte = dout;
  end
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      end_of_test();
    end
  end
  ulpiss_top #(.CHIP_SEL_ACTIVE_HIGH(1'b1)) i_ulpiss_top (
    .clk(clk), .reset(reset), .io_supply_ok(io_ok), .core_supply_ok(core_ok),
    .pll_locked(pll), .chip_sel_pin(csel), .func_reset_set(rst_set),
    .bus_guard_disable(gdis), .link_xfer_active(xfer), .line_status(8'h5A),
    .stp_in(stp), .stp_pullup_en(), .dir_out(dir), .dir_oe(dir_oe),
    .nxt_out(nxt), .nxt_oe(nxt_oe), .data_out(dout), .data_oe(doe),
    .data_pulldown_en(pd), .clock_run(crun), .clock_oe(),
    .func_reset_bit(fbit), .regulator_en(reg_en), .rxcmd_sent(rx)
  );
  ulpiss_link_model i_ulpiss_link_model (
    .clk(clk), .reset(reset), .go(go), .dir_out(dir), .dir_oe(dir_oe),
    .func_reset_set(rst_set), .link_data(ldata)
  );
  task automatic chk(input string what, input logic [7:0] e,
    input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic end_of_test;
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // waits, bounded, for dir to reach a level
  task automatic wait_dir(input logic lvl, output int n);
    n = 0;
    while (dir !== lvl && n < 400) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask
  task automatic t_powerup;
    int n;
    @(posedge clk);
    {io_ok, core_ok, csel} <= 3'h7;
    repeat (30) @(posedge clk);
    #1;
    chk("dir in por", 8'h01, {7'h00, dir});
    chk("clock in por", 8'h00, {7'h00, crun});
    @(posedge clk);
    pll <= 1'b1;
    wait_dir(1'b0, n);
    chk("clock after pll", 8'h01, {7'h00, crun});
    chk("nxt idle driven", 8'h02, {6'h00, nxt_oe, nxt});
    chk("status count", 8'h01, 8'(rx_n));
    chk("status byte", 8'h5A, rx_byte);
  endtask
  task automatic t_reset;
    int n;
    int r0;
    r0 = rx_n;
    @(posedge clk);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    wait_dir(1'b1, n);
    chk("reset bit", 8'h01, {7'h00, fbit});
    wait_dir(1'b0, n);
    chk("reset length", 8'h66, 8'(n));
    chk("bit cleared", 8'h00, {7'h00, fbit});
    chk("status after reset", 8'h01, 8'(rx_n - r0));
  endtask
  task automatic t_guard;
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      {stp, gdis, xfer} <= (i == 0) ? 3'h4 : (i == 1) ? 3'h6 : 3'h5;
      repeat (6) @(posedge clk);
      #1;
      chk("pull-down", (i == 0) ? 8'h01 : 8'h00, {7'h00, pd});
    end
    @(posedge clk);
    {stp, gdis, xfer} <= 3'h0;
  endtask
  task automatic t_brown;
    int n;
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      core_ok <= 1'b0;
      repeat ((i == 0) ? 10 : 60) @(posedge clk);
      core_ok <= 1'b1;
      if (i == 0) repeat (20) @(posedge clk);
      else wait_dir(1'b1, n);
      #1;
      chk("dip", (i == 0) ? 8'h00 : 8'h01, {7'h00, dir});
    end
    wait_dir(1'b0, n);
  endtask
  task automatic t_desel;
    int n;
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      {io_ok, csel, stp} <= (i == 0) ? 3'h5 : 3'h3;
      repeat (6) @(posedge clk);
      #1;
      chk("pins off", 8'h00, {4'h0, nxt_oe, doe, crun, dir_oe});
      chk("stp ignored", 8'h00, {6'h00, pd, reg_en});
      @(posedge clk);
      {io_ok, csel, stp} <= 3'h6;
      wait_dir(1'b1, n);
      wait_dir(1'b0, n);
      chk("restart", 8'h01, {7'h00, crun});
    end
  endtask
  // main sequence
  initial begin
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    t_powerup();
    t_reset();
    t_reset();
    t_guard();
    t_brown();
    t_desel();
    end_of_test();
  end
endmodule
`default_nettype wire

//--- testbench/ulpiss_link_model.sv
// link controller model: writes the reset bit when asked
// assumes dir_out and dir_oe come straight from the sequencer
`timescale 1ns/10ps
`default_nettype none
module ulpiss_link_model (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // bench request and direction pin
  input wire logic go,
  input wire logic dir_out,
  input wire logic dir_oe,
  // to the sequencer
  output logic func_reset_set,
  output ulpiss_pkg::ulpiss_byte_t link_data
);
  logic pend_r;
  logic [1:0] low_r;
  // counts cycles of dir low, including the turnaround cycle, up to three
  always_ff @(posedge clk) begin
    if (reset || !dir_oe || dir_out) low_r <= 2'h0;
    else if (low_r != 2'h3) low_r <= low_r + 2'h1;
  end
  // writes the reset bit only once the bus is ours
  always_ff @(posedge clk) begin
    func_reset_set <= 1'b0;
    if (reset) pend_r <= 1'b0;
    else if (go) pend_r <= 1'b1;
    else if (pend_r && low_r == 2'h3) begin
      pend_r <= 1'b0;
      func_reset_set <= 1'b1;
    end
  end
  // idle bus value while dir is low
  assign link_data = 8'h00;
endmodule
`default_nettype wire

//--- testbench/ulpiss_top_asserts.sv
// port checker for the ulpi start-up sequencer
// assumes it is bound into ulpiss_top on its single clock
`timescale 1ns/10ps
`default_nettype none
module ulpiss_top_asserts (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // watched ports
  input wire logic bus_guard_disable,
  input wire logic link_xfer_active,
  input wire logic stp_in,
  input wire logic stp_pullup_en,
  input wire logic dir_out,
  input wire logic data_oe,
  input wire logic data_pulldown_en,
  input wire logic clock_run,
  input wire logic clock_oe,
  input wire logic func_reset_bit,
  input wire logic regulator_en,
  input wire logic rxcmd_sent
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // power-down floats the data and clock pins and ignores stp
  property p_float;
    !regulator_en |-> !data_oe && !clock_oe && !data_pulldown_en;
  endproperty
  a_float: assert property (p_float)
    else $error("pins not floated");
  // stp pull-up whenever powered
  property p_pu; regulator_en |-> stp_pullup_en; endproperty
  a_pu: assert property (p_pu) else $error("no stp pull-up");
  // no data driven in a direction change cycle
  property p_ta; $changed(dir_out) |-> !data_oe; endproperty
  a_ta: assert property (p_ta) else $error("no turnaround");
  // clock runs once direction is released
  property p_clk; $fell(dir_out) && regulator_en |-> clock_run; endproperty
  a_clk: assert property (p_clk) else $error("clock idle");
  // status byte is driven, then the bus is handed back
  property p_stat; rxcmd_sent |-> dir_out && data_oe ##1 !dir_out; endproperty
  a_stat: assert property (p_stat) else $error("bad status byte");
  // internal reset lasts its full length, then clears the bit
  property p_rlen;
    $rose(func_reset_bit) && $rose(dir_out) |->
      ##101 rxcmd_sent && !func_reset_bit;
  endproperty
  a_rlen: assert property (p_rlen) else $error("reset length");
  // guard disable keeps the pull-downs off
  property p_gd; bus_guard_disable |=> !data_pulldown_en; endproperty
  a_gd: assert property (p_gd) else $error("guard not off");
  // stray stp switches on the data pull-downs
  property p_prot;
    (stp_in && !link_xfer_active && !bus_guard_disable && !dir_out &&
      regulator_en) [*4] |=> data_pulldown_en;
  endproperty
  a_prot: assert property (p_prot) else $error("no guard");
  // power-on raises direction within 8 cycles
  property p_por; $rose(regulator_en) |-> ##[1:8] dir_out; endproperty
  a_por: assert property (p_por) else $error("dir low in por");
endmodule
bind ulpiss_top ulpiss_top_asserts i_ulpiss_top_asserts (
  .clk(clk), .reset(reset), .bus_guard_disable(bus_guard_disable),
  .link_xfer_active(link_xfer_active), .stp_in(stp_in),
  .stp_pullup_en(stp_pullup_en), .dir_out(dir_out), .data_oe(data_oe),
  .data_pulldown_en(data_pulldown_en), .clock_run(clock_run),
  .clock_oe(clock_oe), .func_reset_bit(func_reset_bit),
  .regulator_en(regulator_en), .rxcmd_sent(rxcmd_sent)
);
`default_nettype wire
